// *** cfg_image_pkg.sv ***
// constants for the configuration image access block
package cfg_image_pkg;
  // register map (byte offsets on the register port)
  localparam logic [7:0] ctrl_offset = 8'h89;
  localparam logic [7:0] index_high_offset = 8'h8b;
  localparam logic [7:0] index_low_offset = 8'h8c;
  localparam logic [7:0] nv_data_offset = 8'h8d;
  localparam logic [7:0] sram_data_offset = 8'h8e;
  localparam logic [7:0] unlock_offset = 8'h92;
  localparam logic [7:0] lock_offset = 8'h90;
  localparam logic [7:0] commit_page_offset = 8'h91;
  // image layout
  localparam int image_bytes = 345;
  localparam logic [8:0] last_index = 9'h158;
  localparam int page_count = 6;
  localparam logic [8:0] common_first = 9'h000;
  localparam logic [8:0] common_bytes = 9'h027;
  localparam logic [8:0] page_bytes = 9'h033;
  // program sequence values
  localparam logic [7:0] unlock_key = 8'hea;
  localparam logic [7:0] program_arm = 8'h13;
  localparam logic [7:0] program_go = 8'h10;
  localparam int commit_bit = 0;
  // reset values
  localparam logic [15:0] index_reset = 16'h0000;
  localparam logic [2:0] page_reset = 3'h0;
endpackage

// *** cfg_image_mem.sv ***
// single-port byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cfg_image_mem
#(
  parameter int depth = 345,
  parameter int aw = 9
)
(
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [aw-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [depth];

  always_ff @(posedge clk_in)
  begin
    if (we_in)
    begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule // cfg_image_mem
`default_nettype wire

// *** cfg_image_access.sv ***
// configuration image access: sram and nonvolatile copies behind a byte register port
`timescale 1ns/1ps
`default_nettype none
// Operation
// - image holds one common partition then six page partitions.
// - common partition is shared by every page and written on each commit.
// - memory index is high and low bytes joined, valid 0 to 0158h.
// - each indexed location stores a full eight-bit value.
// - host reads every sram byte through the sram data port.
// - host reads every nonvolatile byte through its own data port.
// - commit copies live settings into selected page and common partition only.
// - index set by two byte writes, then sram data write stores byte.
// - unlock key, then 13h then 10h to control starts programming; then relock.
// - commit page comes from page select; commit bit rising toggle starts commit.
module cfg_image_access
  import cfg_image_pkg::*;
#(
  parameter int aw = 9
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] live_data_in,
  output logic [8:0] live_index_out,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic busy_out
);
  typedef enum {idle, commit_rd, commit_wr, prog_rd, prog_wr} state_e;
  state_e state;
  logic [15:0] memory_index_register;
  logic [2:0] commit_page_select;
  logic unlocked;
  logic armed;
  logic commit_seen;
  logic [8:0] walk;
  logic [8:0] walk_end;
  logic sram_we;
  logic [8:0] sram_addr;
  logic [7:0] sram_wdata;
  logic [7:0] sram_q;
  logic [7:0] nv_q;
  logic nv_we;
  logic rd_pend;
  logic [7:0] rd_sel;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [8:0] page_start(input logic [2:0] pg);
    page_start = 9'(common_bytes + 9'(pg) * page_bytes);
  endfunction
  function automatic logic [8:0] clip_index(input logic [15:0] idx);
    clip_index = (idx > 16'(last_index)) ? last_index : idx[8:0];
  endfunction
  // ----------------------------------------
  // host register writes
  // ----------------------------------------
  wire logic host_wr = wr_in && (state == idle);
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      memory_index_register <= index_reset;
      commit_page_select <= page_reset;
    end
    else if (host_wr && addr_in == index_high_offset)
    begin
      memory_index_register[15:8] <= wdata_in;
    end
    else if (host_wr && addr_in == index_low_offset)
    begin
      memory_index_register[7:0] <= wdata_in;
    end
    else if (host_wr && addr_in == commit_page_offset && wdata_in < 8'(page_count))
    begin
      commit_page_select <= wdata_in[2:0];
    end
  end
  // unlock register: key opens, any other value (including 00h) locks
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      unlocked <= 1'b0;
    end
    else if (host_wr && (addr_in == unlock_offset || addr_in == lock_offset))
    begin
      unlocked <= (wdata_in == unlock_key);
    end
  end
  // arm on 13h, fire on a following 10h; the commit bit acts on its rising toggle
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      armed <= 1'b0;
      commit_seen <= 1'b0;
    end
    else if (host_wr && addr_in == ctrl_offset)
    begin
      armed <= (wdata_in == program_arm);
      commit_seen <= wdata_in[commit_bit];
    end
  end
  wire logic ctrl_wr = host_wr && addr_in == ctrl_offset;
  wire logic start_prog = ctrl_wr && armed && wdata_in == program_go && unlocked;
  wire logic start_commit = ctrl_wr && wdata_in[commit_bit] && !commit_seen && !(wdata_in == program_arm);
  // ----------------------------------------
  // copy engine: commit walks common then page, program walks whole image
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state <= idle;
      walk <= 9'h000;
      walk_end <= 9'h000;
      live_index_out <= 9'h000;
      busy_out <= 1'b0;
    end
    else
    begin
      live_index_out <= walk;
      busy_out <= (state != idle) || start_prog || start_commit;
      unique case (state)
        idle:
        begin
          if (start_prog)
          begin
            state <= prog_rd;
            walk <= common_first;
            walk_end <= last_index;
          end
          else if (start_commit)
          begin
            state <= commit_rd;
            walk <= common_first;
            walk_end <= 9'(common_bytes - 9'h001);
          end
        end
        commit_rd:
        begin
          state <= commit_wr;
        end
        commit_wr:
        begin
          if (walk == walk_end && walk < common_bytes)
          begin
            // common done, move to selected page; other pages untouched
            walk <= page_start(commit_page_select);
            walk_end <= 9'(page_start(commit_page_select) + page_bytes - 9'h001);
            state <= commit_rd;
          end
          else if (walk == walk_end)
          begin
            state <= idle;
          end
          else
          begin
            walk <= 9'(walk + 9'h001);
            state <= commit_rd;
          end
        end
        prog_rd:
        begin
          state <= prog_wr;
        end
        prog_wr:
        begin
          if (walk == walk_end)
          begin
            state <= idle;
          end
          else
          begin
            walk <= 9'(walk + 9'h001);
            state <= prog_rd;
          end
        end
      endcase
    end
  end
  always_comb
  begin
    sram_we = 1'b0;
    sram_addr = clip_index(memory_index_register);
    sram_wdata = wdata_in;
    nv_we = 1'b0;
    if (state == commit_wr)
    begin
      sram_we = 1'b1;
      sram_addr = walk;
      sram_wdata = live_data_in;
    end
    else if (state == prog_rd || state == prog_wr)
    begin
      sram_addr = walk;
      nv_we = (state == prog_wr);
    end
    else if (host_wr && addr_in == sram_data_offset && memory_index_register <= 16'(last_index))
    begin
      sram_we = 1'b1;
    end
  end
  cfg_image_mem #(.depth(image_bytes), .aw(aw)) sram_u
  (
    .clk_in(clk_in),
    .we_in(sram_we),
    .addr_in(sram_addr),
    .wdata_in(sram_wdata),
    .rdata_out(sram_q)
  );
  // nonvolatile copy takes its source straight from sram; host loads sram first
  cfg_image_mem #(.depth(image_bytes), .aw(aw)) nv_u
  (
    .clk_in(clk_in),
    .we_in(nv_we),
    .addr_in(sram_addr),
    .wdata_in(sram_q),
    .rdata_out(nv_q)
  );
  // ----------------------------------------
  // host reads: memory answers one cycle later, registered out the next
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rd_pend <= 1'b0;
      rd_sel <= 8'h00;
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rd_pend <= rd_in && (state == idle);
      rd_sel <= addr_in;
      rvalid_out <= rd_pend;
      if (rd_pend)
      begin
        unique case (rd_sel)
          sram_data_offset: rdata_out <= sram_q;
          nv_data_offset: rdata_out <= nv_q;
          index_high_offset: rdata_out <= memory_index_register[15:8];
          index_low_offset: rdata_out <= memory_index_register[7:0];
          commit_page_offset: rdata_out <= {5'h00, commit_page_select};
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking check_cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_read_taken;
    rd_in && state == idle;
  endsequence
  sequence s_read_answer;
    ##2 rvalid_out;
  endsequence
  a_locked_no_program: assert property (nv_we |-> unlocked && sram_addr == walk)
    else $error("nonvolatile written while locked");
  a_prog_needs_unlock: assert property (ctrl_wr && wdata_in == program_go && !unlocked |=> state == idle)
    else $error("program started while locked");
  a_commit_page_only: assert property ((state == commit_wr && walk >= common_bytes) |->
    (walk >= page_start(commit_page_select) && walk < 9'(page_start(commit_page_select) + page_bytes)))
    else $error("commit wrote outside selected page");
  a_index_range: assert property (sram_we |-> sram_addr <= last_index)
    else $error("sram write beyond image");
  a_read_answer: assert property (s_read_taken |-> s_read_answer)
    else $error("read not answered in two cycles");
  a_read_no_write: assert property (rd_in && !wr_in && state == idle |->
    !sram_we ##1 $stable(memory_index_register))
    else $error("read disturbed sram or index");
  a_busy_follows: assert property (start_commit |=> busy_out && state == commit_rd)
    else $error("commit did not start");
  a_sram_write: assert property (host_wr && addr_in == sram_data_offset
    && memory_index_register <= 16'(last_index) |-> sram_we && sram_wdata == wdata_in)
    else $error("sram data write lost");
endmodule // cfg_image_access
`default_nettype wire

// *** cfg_live_settings.sv ***
// live setting source model standing behind the commit engine
`timescale 1ns/1ps
`default_nettype none
module cfg_live_settings
(
  input wire logic [8:0] index_in,
  output logic [7:0] data_out
);
  // --------------------------------
  // live settings
  // --------------------------------
  // pattern depends on every index bit; bit 8 folds into bit 0, so indexes 001h and 100h give the same value
  assign data_out = index_in[7:0] ^ 8'h3c ^ {7'h00, index_in[8]};
endmodule // cfg_live_settings
`default_nettype wire

// *** config_image_sram_eeprom_access_test.sv ***
// self-checking testbench for the configuration image access block
`timescale 1ns/1ps
`default_nettype none
module config_image_sram_eeprom_access_test
  import cfg_image_pkg::*;
;
  logic clk_in, resetn_in, wr_in, rd_in, rvalid_out, busy_out;
  logic [7:0] addr_in, wdata_in, live_data_in, rdata_out;
  logic [8:0] live_index_out;
  logic [7:0] img [0:344];
  logic [7:0] nv [0:344];
  logic [7:0] expq [$];
  int fail_count = 0;
  int comparisons = 0;
  cfg_image_access dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .wr_in(wr_in), .rd_in(rd_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .live_data_in(live_data_in), .live_index_out(live_index_out),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out), .busy_out(busy_out));
  cfg_live_settings live_u (.index_in(live_index_out), .data_out(live_data_in));
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // strobe drops a full cycle before the next request may rise
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_in = 1'b1;
    addr_in = a;
    wdata_in = d;
    @(negedge clk_in);
    wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    @(negedge clk_in);
    rd_in = 1'b1;
    addr_in = a;
    @(negedge clk_in);
    rd_in = 1'b0;
  endtask
  task automatic set_index(input logic [8:0] i);
    wr(index_high_offset, {7'h00, i[8]});
    wr(index_low_offset, i[7:0]);
  endtask
  task automatic sram_wr(input logic [8:0] i, input logic [7:0] d);
    set_index(i);
    wr(sram_data_offset, d);
  endtask
  task automatic sram_rd(input logic [8:0] i, input logic [7:0] e);
    set_index(i);
    rd(sram_data_offset, e);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 2000 && busy_out !== 1'b0; n++)
      @(negedge clk_in);
    if (busy_out !== 1'b0)
    begin
      fail_count++;
      $display("unexpected at %0t: engine stuck busy", $time);
      finish_test();
    end
  endtask
  task automatic program_nv(input bit unl);
    if (unl)
      wr(unlock_offset, unlock_key);
    wr(ctrl_offset, program_arm);
    wr(ctrl_offset, program_go);
    @(negedge clk_in);
    if (unl)
      cmp({7'h00, busy_out}, 8'h01);
    wait_idle();
    wr(unlock_offset, 8'h00);
  endtask
  // --------------------------------
  // result watcher
  // --------------------------------
  always @(negedge clk_in)
    if (rvalid_out === 1'b1)
    begin
      if (expq.size() == 0)
      begin
        fail_count++;
        $display("unexpected at %0t: answer without a read", $time);
      end
      else
        cmp(rdata_out, expq.pop_front());
    end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    int b;
    resetn_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    void'($urandom(19));
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    for (int i = 0; i < image_bytes; i++)
    begin
      img[i] = 8'($urandom);
      sram_wr(i[8:0], img[i]);
    end
    sram_rd(9'h000, img[0]);
    sram_rd(last_index, img[344]);
    rd(sram_data_offset, img[344]);
    sram_wr(9'h159, ~img[344]);
    sram_rd(9'h159, img[344]);
    rd(8'h80, 8'h00);
    program_nv(1'b1);
    for (int i = 0; i < image_bytes; i++)
    begin
      nv[i] = img[i];
      set_index(i[8:0]);
      rd(nv_data_offset, nv[i]);
    end
    // locked program must leave the nonvolatile copy alone
    img[5] = ~img[5];
    sram_wr(9'h005, img[5]);
    wr(unlock_offset, unlock_key);
    wr(lock_offset, 8'h00);
    program_nv(1'b0);
    rd(nv_data_offset, nv[5]);
    rd(sram_data_offset, img[5]);
    for (int p = 0; p < page_count; p++)
    begin
      b = int'(common_bytes) + int'(page_bytes) * p;
      wr(commit_page_offset, 8'(p));
      wr(commit_page_offset, 8'(page_count));
      rd(commit_page_offset, 8'(p));
      wr(ctrl_offset, 8'h00);
      wr(ctrl_offset, 8'h01);
      @(negedge clk_in);
      cmp({7'h00, busy_out}, 8'h01);
      // writes are refused while the engine runs
      wr(index_low_offset, 8'h77);
      wait_idle();
      rd(index_low_offset, (p == 0) ? 8'h05 : 8'(b));
      for (int i = 0; i < image_bytes; i++)
        if (i < int'(common_bytes) || (i >= b && i < b + int'(page_bytes)))
          img[i] = i[7:0] ^ 8'h3c ^ {7'h00, i[8]};
      sram_rd(9'h000, img[0]);
      sram_rd(9'd38, img[38]);
      sram_rd(9'(b), img[b]);
      sram_rd(9'(b + 50), img[b + 50]);
      if (p < 5)
        sram_rd(9'(b + 51), img[b + 51]);
    end
    // second reset mid-run: registers and outputs clear, memory keeps its bytes
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b0;
    @(negedge clk_in);
    cmp({7'h00, busy_out}, 8'h00);
    cmp(rdata_out, 8'h00);
    cmp(live_index_out[7:0], 8'h00);
    resetn_in = 1'b1;
    rd(index_low_offset, 8'h00);
    rd(commit_page_offset, 8'h00);
    sram_rd(9'h000, img[0]);
    for (int n = 0; n < 20 && expq.size() > 0; n++)
      @(negedge clk_in);
    if (expq.size() > 0)
    begin
      fail_count++;
      $display("unexpected at %0t: missing read answers", $time);
    end
    finish_test();
  end
endmodule // config_image_sram_eeprom_access_test
`default_nettype wire
